// file: common/ctimer_pkg.sv
package ctimer_pkg;
    // Byte register offsets on the processor data bus
    localparam logic [3:0] ADDR_COUNT_LO = 4'h0;
    localparam logic [3:0] ADDR_COUNT_HI = 4'h1;
    localparam logic [3:0] ADDR_CAP_LO = 4'h2;
    localparam logic [3:0] ADDR_CAP_HI = 4'h3;
    localparam logic [3:0] ADDR_CTRL_A = 4'h4;
    localparam logic [3:0] ADDR_CTRL_B = 4'h5;
    localparam logic [3:0] ADDR_FLAGS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
    localparam logic [3:0] ADDR_CMP_CTRL = 4'h8;
    // Field positions
    localparam int CTRL_A_WGM_LSB = 0;
    localparam int CTRL_B_CS_LSB = 0;
    localparam int CTRL_B_WGM_LSB = 3;
    localparam int CTRL_B_EDGE_BIT = 6;
    localparam int CTRL_B_NF_BIT = 7;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_CAP_BIT = 5;
    localparam int CMP_SEL_BIT = 3;
    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // Count limits
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    // Noise filter length in system clocks
    localparam int FILTER_SAMPLES = 4;
    // Clock source select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    typedef enum logic [1:0] {
        KIND_NORMAL,
        KIND_SINGLE,
        KIND_CTC,
        KIND_DUAL
    } count_kind_t;

    // Modes that take their top from the capture register
    function automatic logic uses_cap_top(input logic [3:0] mode);
        uses_cap_top = (mode == 4'h8) || (mode == 4'ha) ||
                       (mode == 4'hc) || (mode == 4'he);
    endfunction : uses_cap_top

    function automatic count_kind_t kind_of(input logic [3:0] mode);
        case (mode)
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: kind_of = KIND_DUAL;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: kind_of = KIND_SINGLE;
            4'h4, 4'hc: kind_of = KIND_CTC;
            default: kind_of = KIND_NORMAL;
        endcase
    endfunction : kind_of

    function automatic logic [15:0] top_of(input logic [3:0] mode,
                                           input logic [15:0] cap);
        case (mode)
            4'h1, 4'h5: top_of = TOP_8BIT;
            4'h2, 4'h6: top_of = TOP_9BIT;
            4'h3, 4'h7: top_of = TOP_10BIT;
            4'h8, 4'ha, 4'hc, 4'he: top_of = cap;
            default: top_of = COUNT_MAX;
        endcase
    endfunction : top_of
endpackage : ctimer_pkg

// file: common/edge_path_if.sv
`timescale 1ns/10ps
interface edge_path_if;
    logic raw;
    logic filt_en;
    logic level;
    modport source (output raw, output filt_en, input level);
    modport filter (input raw, input filt_en, output level);
endinterface : edge_path_if

// file: design/tick_select.sv
`timescale 1ns/10ps
module tick_select #(
    parameter int PRE_WIDTH = 10
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [2:0] clock_source_select_i,
    input wire logic ext_clk_pin_i,
    output logic timer_tick_o
);
    logic [PRE_WIDTH-1:0] pre_q;
    logic ext_q;
    logic ext_prev_q;

    // Free running prescaler
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pre_q <= '0;
        else
            pre_q <= pre_q + 1'b1;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ext_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end
        else
        begin
            ext_q <= ext_clk_pin_i;
            ext_prev_q <= ext_q;
        end
    end

    // Tick source selection; code zero stops the timer
    always_comb
    begin
        case (clock_source_select_i)
            ctimer_pkg::CS_STOP: timer_tick_o = 1'b0;
            ctimer_pkg::CS_DIV1: timer_tick_o = 1'b1;
            ctimer_pkg::CS_DIV8: timer_tick_o = &pre_q[2:0];
            ctimer_pkg::CS_DIV64: timer_tick_o = &pre_q[5:0];
            ctimer_pkg::CS_DIV256: timer_tick_o = &pre_q[7:0];
            ctimer_pkg::CS_DIV1024: timer_tick_o = &pre_q[9:0];
            ctimer_pkg::CS_EXT_FALL: timer_tick_o = ext_prev_q & ~ext_q;
            ctimer_pkg::CS_EXT_RISE: timer_tick_o = ext_q & ~ext_prev_q;
            default: timer_tick_o = 1'b0;
        endcase
    end
endmodule : tick_select

// file: design/capture_filter.sv
`timescale 1ns/10ps
module capture_filter (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    edge_path_if.filter path
);
    localparam int N = ctimer_pkg::FILTER_SAMPLES;
    logic [N-1:0] hist_q;
    logic level_q;

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            hist_q <= '0;
        else
            hist_q <= {hist_q[N-2:0], path.raw};
    end

    // With the filter on, output moves only on a full run of equal samples
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            level_q <= 1'b0;
        else if (!path.filt_en)
            level_q <= path.raw;
        else if (&hist_q)
            level_q <= 1'b1;
        else if (~|hist_q)
            level_q <= 1'b0;
    end

    assign path.level = level_q;

    chk_filter_hold: assert property (
        @(posedge sys_clk_i) disable iff (!rstn_i)
        path.filt_en && (|hist_q) && !(&hist_q) |=> $stable(level_q))
        else $error("filtered level moved on mixed samples");
endmodule : capture_filter

// file: design/capture_timer_16bit.sv
`timescale 1ns/10ps
// Overview of operation
// - Count appears as low and high bytes; high location reaches holding
// - Low read loads holding; low write loads count high from holding
// - Whole sixteen-bit value moves in one clock cycle
// - One holding register shared by all sixteen-bit registers
// - Holding keeps its value after a low-byte write
// - Counter clears, increments or decrements per tick by mode
// - Three-bit clock source field picks tick; zero stops timer
// - Counter readable and writable with or without ticks
// - Processor write beats clear or count in same cycle
// - Four-bit mode field split over control registers A and B
// - Overflow flag set where mode says; can request interrupt
// - Top and bottom indications produced
// - Capture on selected edge of pin or comparator output
// - Capture copies counter into capture register
// - Capture flag set in same cycle as copy
// - Capture flag requests interrupt when enabled; cleared on service
// - Writing one clears capture flag; zero leaves it
// - Capture low read first loads holding; high returns holding
// - Capture writes accepted only in capture-top modes
// - Optional filter needs four equal samples, adds four cycles
// - Capture input disabled in capture-top modes
// - Bottom is 0x0000, maximum is 0xffff
module capture_timer_16bit #(
    parameter int PRE_WIDTH = 10
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] addr_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic capture_pin_i,
    input wire logic comparator_output_i,
    input wire logic ext_clk_pin_i,
    input wire logic capture_irq_ack_i,
    input wire logic overflow_irq_ack_i,
    output logic capture_irq_o,
    output logic overflow_irq_o,
    output logic at_top_o,
    output logic at_bottom_o
);
    logic [15:0] timer_count_q, count_d;
    logic [15:0] capture_value_q;
    logic [7:0] hold_q;
    logic [7:0] control_reg_a_q, control_reg_b_q;
    logic [7:0] irq_en_q, cmp_ctrl_q, rdata_q;
    logic dir_down_q, dir_d;
    logic overflow_flag_q, capture_flag_q;
    logic cap_irq_q, ovf_irq_q, at_top_q, at_bottom_q;
    logic level_prev_q;
    logic timer_tick, ovf_set, cap_trig, cap_block;
    logic [3:0] waveform_mode_field;
    logic [15:0] top_val;
    ctimer_pkg::count_kind_t kind;

    logic wr_cnt_lo, wr_cnt_hi, wr_cap_lo, wr_cap_hi;
    logic rd_cnt_lo, rd_cap_lo, wr_flags;

    assign wr_cnt_lo = wr_en_i && addr_i == ctimer_pkg::ADDR_COUNT_LO;
    assign wr_cnt_hi = wr_en_i && addr_i == ctimer_pkg::ADDR_COUNT_HI;
    assign wr_cap_lo = wr_en_i && addr_i == ctimer_pkg::ADDR_CAP_LO;
    assign wr_cap_hi = wr_en_i && addr_i == ctimer_pkg::ADDR_CAP_HI;
    assign wr_flags = wr_en_i && addr_i == ctimer_pkg::ADDR_FLAGS;
    assign rd_cnt_lo = rd_en_i && addr_i == ctimer_pkg::ADDR_COUNT_LO;
    assign rd_cap_lo = rd_en_i && addr_i == ctimer_pkg::ADDR_CAP_LO;

    // Mode field gathered from both control registers
    assign waveform_mode_field = {
        control_reg_b_q[ctimer_pkg::CTRL_B_WGM_LSB +: 2],
        control_reg_a_q[ctimer_pkg::CTRL_A_WGM_LSB +: 2]};
    assign kind = ctimer_pkg::kind_of(waveform_mode_field);
    assign top_val = ctimer_pkg::top_of(waveform_mode_field,
                                        capture_value_q);
    assign cap_block = ctimer_pkg::uses_cap_top(waveform_mode_field);

    tick_select #(
        .PRE_WIDTH(PRE_WIDTH)
    ) u_tick (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .clock_source_select_i(
            control_reg_b_q[ctimer_pkg::CTRL_B_CS_LSB +: 3]),
        .ext_clk_pin_i(ext_clk_pin_i),
        .timer_tick_o(timer_tick)
    );

    edge_path_if edge_path ();

    // Source select and filter enable
    assign edge_path.raw = cmp_ctrl_q[ctimer_pkg::CMP_SEL_BIT] ?
        comparator_output_i : capture_pin_i;
    assign edge_path.filt_en = control_reg_b_q[ctimer_pkg::CTRL_B_NF_BIT];

    capture_filter u_filter (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .path(edge_path.filter)
    );

    // Edge detector, held off in capture-top modes
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            level_prev_q <= 1'b0;
        else
            level_prev_q <= edge_path.level;
    end

    assign cap_trig = !cap_block &&
        (control_reg_b_q[ctimer_pkg::CTRL_B_EDGE_BIT] ?
            (edge_path.level && !level_prev_q) :
            (!edge_path.level && level_prev_q));

    // Next count; a processor write overrides counting
    always_comb
    begin
        count_d = timer_count_q;
        dir_d = dir_down_q;
        ovf_set = 1'b0;
        if (timer_tick)
        begin
            case (kind)
                ctimer_pkg::KIND_DUAL:
                begin
                    if (!dir_down_q)
                    begin
                        if (timer_count_q >= top_val)
                        begin
                            dir_d = 1'b1;
                            count_d = timer_count_q - 16'h0001;
                        end
                        else
                            count_d = timer_count_q + 16'h0001;
                    end
                    else if (timer_count_q == ctimer_pkg::COUNT_BOTTOM)
                    begin
                        dir_d = 1'b0;
                        count_d = timer_count_q + 16'h0001;
                    end
                    else
                    begin
                        count_d = timer_count_q - 16'h0001;
                        ovf_set = (timer_count_q == 16'h0001);
                    end
                end
                ctimer_pkg::KIND_SINGLE:
                begin
                    dir_d = 1'b0;
                    if (timer_count_q >= top_val)
                    begin
                        count_d = ctimer_pkg::COUNT_BOTTOM;
                        ovf_set = 1'b1;
                    end
                    else
                        count_d = timer_count_q + 16'h0001;
                end
                ctimer_pkg::KIND_CTC:
                begin
                    dir_d = 1'b0;
                    ovf_set = (timer_count_q == ctimer_pkg::COUNT_MAX);
                    if (timer_count_q >= top_val)
                        count_d = ctimer_pkg::COUNT_BOTTOM;
                    else
                        count_d = timer_count_q + 16'h0001;
                end
                default:
                begin
                    dir_d = 1'b0;
                    count_d = timer_count_q + 16'h0001;
                    ovf_set = (timer_count_q == ctimer_pkg::COUNT_MAX);
                end
            endcase
        end
        if (wr_cnt_lo)
            count_d = {hold_q, wdata_i};
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            timer_count_q <= ctimer_pkg::WORD_RESET;
            dir_down_q <= 1'b0;
        end
        else
        begin
            timer_count_q <= count_d;
            dir_down_q <= dir_d;
        end
    end

    // Shared holding byte for every sixteen-bit register
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            hold_q <= ctimer_pkg::BYTE_RESET;
        else if (wr_cnt_hi || wr_cap_hi)
            hold_q <= wdata_i;
        else if (rd_cnt_lo)
            hold_q <= timer_count_q[15:8];
        else if (rd_cap_lo)
            hold_q <= capture_value_q[15:8];
    end

    // Capture register; writes only in capture-top modes
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            capture_value_q <= ctimer_pkg::WORD_RESET;
        else if (cap_trig)
            capture_value_q <= timer_count_q;
        else if (wr_cap_lo && cap_block)
            capture_value_q <= {hold_q, wdata_i};
    end

    // Sticky flags; a set wins over any clear
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            capture_flag_q <= 1'b0;
            overflow_flag_q <= 1'b0;
        end
        else
        begin
            if (cap_trig)
                capture_flag_q <= 1'b1;
            else if (capture_irq_ack_i ||
                     (wr_flags && wdata_i[ctimer_pkg::FLAG_CAP_BIT]))
                capture_flag_q <= 1'b0;
            if (ovf_set)
                overflow_flag_q <= 1'b1;
            else if (overflow_irq_ack_i ||
                     (wr_flags && wdata_i[ctimer_pkg::FLAG_OVF_BIT]))
                overflow_flag_q <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            control_reg_a_q <= ctimer_pkg::BYTE_RESET;
            control_reg_b_q <= ctimer_pkg::BYTE_RESET;
            irq_en_q <= ctimer_pkg::BYTE_RESET;
            cmp_ctrl_q <= ctimer_pkg::BYTE_RESET;
        end
        else if (wr_en_i)
        begin
            case (addr_i)
                ctimer_pkg::ADDR_CTRL_A: control_reg_a_q <= wdata_i;
                ctimer_pkg::ADDR_CTRL_B: control_reg_b_q <= wdata_i;
                ctimer_pkg::ADDR_IRQ_EN: irq_en_q <= wdata_i;
                ctimer_pkg::ADDR_CMP_CTRL: cmp_ctrl_q <= wdata_i;
                default: ;
            endcase
        end
    end

    // Read data, registered; high locations return the holding byte
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_q <= ctimer_pkg::BYTE_RESET;
        else if (rd_en_i)
        begin
            case (addr_i)
                ctimer_pkg::ADDR_COUNT_LO: rdata_q <= timer_count_q[7:0];
                ctimer_pkg::ADDR_COUNT_HI: rdata_q <= hold_q;
                ctimer_pkg::ADDR_CAP_LO: rdata_q <= capture_value_q[7:0];
                ctimer_pkg::ADDR_CAP_HI: rdata_q <= hold_q;
                ctimer_pkg::ADDR_CTRL_A: rdata_q <= control_reg_a_q;
                ctimer_pkg::ADDR_CTRL_B: rdata_q <= control_reg_b_q;
                ctimer_pkg::ADDR_FLAGS:
                begin
                    rdata_q <= 8'h00;
                    rdata_q[ctimer_pkg::FLAG_CAP_BIT] <= capture_flag_q;
                    rdata_q[ctimer_pkg::FLAG_OVF_BIT] <= overflow_flag_q;
                end
                ctimer_pkg::ADDR_IRQ_EN: rdata_q <= irq_en_q;
                ctimer_pkg::ADDR_CMP_CTRL: rdata_q <= cmp_ctrl_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // Interrupt requests and top/bottom indications
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cap_irq_q <= 1'b0;
            ovf_irq_q <= 1'b0;
            at_top_q <= 1'b0;
            at_bottom_q <= 1'b0;
        end
        else
        begin
            cap_irq_q <= capture_flag_q &&
                irq_en_q[ctimer_pkg::FLAG_CAP_BIT];
            ovf_irq_q <= overflow_flag_q &&
                irq_en_q[ctimer_pkg::FLAG_OVF_BIT];
            at_top_q <= (timer_count_q == top_val);
            at_bottom_q <=
                (timer_count_q == ctimer_pkg::COUNT_BOTTOM);
        end
    end

    assign rdata_o = rdata_q;
    assign capture_irq_o = cap_irq_q;
    assign overflow_irq_o = ovf_irq_q;
    assign at_top_o = at_top_q;
    assign at_bottom_o = at_bottom_q;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    chk_low_read_latch: assert property (
        rd_cnt_lo && !wr_en_i |=> hold_q == $past(timer_count_q[15:8]))
        else $error("holding byte not loaded on low read");
    chk_low_write_wins: assert property (
        wr_cnt_lo |=> timer_count_q == {$past(hold_q), $past(wdata_i)})
        else $error("low write did not load full count");
    chk_hold_kept: assert property (
        wr_cnt_lo |=> $stable(hold_q))
        else $error("holding byte changed by low write");
    chk_high_read: assert property (
        rd_en_i && addr_i == ctimer_pkg::ADDR_COUNT_HI
        |=> rdata_o == $past(hold_q))
        else $error("high read did not return holding byte");
    chk_stopped_hold: assert property (
        control_reg_b_q[2:0] == ctimer_pkg::CS_STOP && !wr_cnt_lo
        |=> $stable(timer_count_q))
        else $error("counter moved while stopped");
    chk_capture_copy: assert property (
        cap_trig |=> capture_value_q == $past(timer_count_q))
        else $error("capture did not copy count");
    chk_flag_with_copy: assert property (
        $changed(capture_value_q) && !$past(wr_cap_lo) |-> capture_flag_q)
        else $error("capture flag not set with copy");
    chk_flag_w1c: assert property (
        wr_flags && wdata_i[ctimer_pkg::FLAG_CAP_BIT] && !cap_trig
        |=> !capture_flag_q)
        else $error("capture flag not cleared by one");
    chk_cap_locked: assert property (
        wr_cap_lo && !cap_block && !cap_trig |=> $stable(capture_value_q))
        else $error("capture register written outside top modes");
    chk_no_cap_top: assert property (
        cap_block |=> !$rose(capture_flag_q))
        else $error("capture fired in capture-top mode");
    chk_cap_irq: assert property (
        capture_flag_q && irq_en_q[ctimer_pkg::FLAG_CAP_BIT]
        |=> capture_irq_o)
        else $error("capture interrupt not requested");

    cov_capture: cover property (cap_trig ##1 capture_irq_ack_i);
    cov_overflow: cover property (ovf_set ##2 overflow_irq_o);
    cov_turn_down: cover property (!dir_down_q ##1 dir_down_q);
    cov_write_count: cover property (wr_cnt_hi ##[1:4] wr_cnt_lo);
endmodule : capture_timer_16bit

// file: dv/cpu_model.sv
`timescale 1ns/10ps
module cpu_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] rdata_i,
    output logic [3:0] addr_o,
    output logic wr_en_o,
    output logic rd_en_o,
    output logic [7:0] wdata_o,
    output logic cap_ack_o,
    output logic ovf_ack_o
);
    initial
    begin
        {addr_o, wr_en_o, rd_en_o, wdata_o, cap_ack_o, ovf_ack_o} = '0;
    end
    // One byte write; bus shows inverted values once released
    task automatic wr_byte(input logic [3:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        {addr_o, wdata_o, wr_en_o} = {a, d, 1'b1};
        @(negedge sys_clk_i);
        {addr_o, wdata_o, wr_en_o} = {~a, ~d, 1'b0};
    endtask : wr_byte
    task automatic rd_byte(input logic [3:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        {addr_o, rd_en_o} = {a, 1'b1};
        @(negedge sys_clk_i);
        {addr_o, rd_en_o} = {~a, 1'b0};
        d = rdata_i;
    endtask : rd_byte
    // Tasks run one at a time, so no pair is split by another access
    task automatic wr_word(input logic [3:0] a, input logic [15:0] v);
        wr_byte(a + 4'h1, v[15:8]);
        wr_byte(a, v[7:0]);
    endtask : wr_word
    task automatic rd_word(input logic [3:0] a, output logic [15:0] v);
        rd_byte(a, v[7:0]);
        rd_byte(a + 4'h1, v[15:8]);
    endtask : rd_word
    // Interrupt service acknowledge pulse
    task automatic ack(input logic cap);
        @(negedge sys_clk_i);
        {cap_ack_o, ovf_ack_o} = {cap, ~cap};
        @(negedge sys_clk_i);
        {cap_ack_o, ovf_ack_o} = 2'b00;
    endtask : ack
endmodule : cpu_model

// file: dv/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic sys_clk_i, rstn_i, pin, cmp, ext, cack, oack, wr, rd;
    logic cirq, oirq, top, bot;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, b;
    logic [15:0] v, c, got;
    int err_total, n_tests, cyc;
    capture_timer_16bit #(.PRE_WIDTH(10)) capture_timer_16bit_i (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr),
        .wr_en_i(wr), .rd_en_i(rd), .wdata_i(wdata), .rdata_o(rdata),
        .capture_pin_i(pin), .comparator_output_i(cmp),
        .ext_clk_pin_i(ext), .capture_irq_ack_i(cack),
        .overflow_irq_ack_i(oack), .capture_irq_o(cirq),
        .overflow_irq_o(oirq), .at_top_o(top), .at_bottom_o(bot));
    cpu_model cpu_model_i (
        .sys_clk_i(sys_clk_i), .rdata_i(rdata), .addr_o(addr),
        .wr_en_o(wr), .rd_en_o(rd), .wdata_o(wdata),
        .cap_ack_o(cack), .ovf_ack_o(oack));
    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    task automatic cmp_word(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : cmp_word
    task automatic cmp_bit(input logic g, input logic e);
        cmp_word({15'h0000, g}, {15'h0000, e});
    endtask : cmp_bit
    // Flag byte with only the capture or overflow bit
    function automatic logic [7:0] flag_of(input logic cap);
        flag_of = cap ? 8'h20 : 8'h01;
    endfunction : flag_of
    task automatic set_mode(input logic [3:0] m, input logic [2:0] cs,
                            input logic e, input logic f);
        cpu_model_i.wr_byte(ctimer_pkg::ADDR_CTRL_A, {6'h00, m[1:0]});
        cpu_model_i.wr_byte(ctimer_pkg::ADDR_CTRL_B, {f, e, 1'b0, m[3:2], cs});
    endtask : set_mode
    task automatic flags(output logic [7:0] f);
        cpu_model_i.rd_byte(ctimer_pkg::ADDR_FLAGS, f);
    endtask : flags
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test();
        end
    end
    initial
    begin
        {rstn_i, pin, cmp, ext} = 4'h0;
        repeat (16) @(posedge sys_clk_i);
        @(negedge sys_clk_i) rstn_i = 1'b1;
        void'($urandom(70621));
        cpu_model_i.rd_word(ctimer_pkg::ADDR_COUNT_LO, got);
        cmp_word(got, 16'h0000);
        cpu_model_i.rd_byte(4'hf, b);
        cmp_word({8'h00, b}, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : $urandom;
            cpu_model_i.wr_word(ctimer_pkg::ADDR_COUNT_LO, v);
            @(negedge sys_clk_i);
            cmp_bit(top, v == 16'hffff);
            cmp_bit(bot, v == 16'h0000);
            cpu_model_i.rd_word(ctimer_pkg::ADDR_COUNT_LO, got);
            cmp_word(got, v);
        end
        v = $urandom;
        cpu_model_i.wr_word(ctimer_pkg::ADDR_COUNT_LO, v);
        cpu_model_i.wr_byte(ctimer_pkg::ADDR_COUNT_LO, ~v[7:0]);
        cpu_model_i.rd_word(ctimer_pkg::ADDR_COUNT_LO, got);
        cmp_word(got, {v[15:8], ~v[7:0]});
        $display("test bytes done");
        cpu_model_i.wr_word(ctimer_pkg::ADDR_COUNT_LO, 16'h0000);
        set_mode(4'h0, ctimer_pkg::CS_EXT_RISE, 1'b0, 1'b0);
        repeat (3)
        begin
            repeat (4) @(negedge sys_clk_i);
            ext = 1'b1;
            repeat (4) @(negedge sys_clk_i);
            ext = 1'b0;
        end
        set_mode(4'h0, ctimer_pkg::CS_STOP, 1'b0, 1'b0);
        repeat (8) @(negedge sys_clk_i);
        cpu_model_i.rd_word(ctimer_pkg::ADDR_COUNT_LO, got);
        cmp_word(got, 16'h0003);
        cpu_model_i.wr_byte(ctimer_pkg::ADDR_IRQ_EN, 8'h21);
        cpu_model_i.wr_word(ctimer_pkg::ADDR_COUNT_LO, 16'hfffe);
        set_mode(4'h0, ctimer_pkg::CS_DIV1, 1'b0, 1'b0);
        set_mode(4'h0, ctimer_pkg::CS_STOP, 1'b0, 1'b0);
        flags(b);
        cmp_word({8'h00, b & 8'h01}, 16'h0001);
        cmp_bit(oirq, 1'b1);
        cpu_model_i.ack(1'b0);
        flags(b);
        cmp_word({8'h00, b & 8'h01}, 16'h0000);
        cpu_model_i.wr_word(ctimer_pkg::ADDR_COUNT_LO, 16'h00fe);
        set_mode(4'h5, ctimer_pkg::CS_DIV1, 1'b0, 1'b0);
        set_mode(4'h5, ctimer_pkg::CS_STOP, 1'b0, 1'b0);
        cpu_model_i.rd_word(ctimer_pkg::ADDR_COUNT_LO, got);
        cmp_word(got, 16'h0002);
        flags(b);
        cmp_word({8'h00, b & 8'h01}, 16'h0001);
        cpu_model_i.wr_byte(ctimer_pkg::ADDR_FLAGS, flag_of(1'b0));
        $display("test ticks done");
        for (int k = 0; k < 4; k++)
        begin
            set_mode(4'h0, ctimer_pkg::CS_STOP, k[1], k == 3);
            cpu_model_i.wr_byte(ctimer_pkg::ADDR_CMP_CTRL, {4'h0, k[0], 3'h0});
            @(negedge sys_clk_i) {pin, cmp} = {2{~k[1]}};
            repeat (12) @(negedge sys_clk_i);
            cpu_model_i.wr_byte(ctimer_pkg::ADDR_FLAGS, flag_of(1'b1));
            v = $urandom;
            cpu_model_i.wr_word(ctimer_pkg::ADDR_COUNT_LO, v);
            @(negedge sys_clk_i) if (k[0]) cmp = k[1]; else pin = k[1];
            repeat (12) @(negedge sys_clk_i);
            flags(b);
            cmp_word({8'h00, b}, {8'h00, flag_of(1'b1)});
            cmp_bit(cirq, 1'b1);
            cpu_model_i.rd_word(ctimer_pkg::ADDR_CAP_LO, got);
            cmp_word(got, v);
            cpu_model_i.wr_byte(ctimer_pkg::ADDR_FLAGS, 8'h00);
            flags(b);
            cmp_word({8'h00, b}, {8'h00, flag_of(1'b1)});
            if (k[0]) cpu_model_i.ack(1'b1);
            else cpu_model_i.wr_byte(ctimer_pkg::ADDR_FLAGS, flag_of(1'b1));
            flags(b);
            cmp_word({8'h00, b}, 16'h0000);
        end
        $display("test capture done");
        c = $urandom;
        set_mode(4'hc, ctimer_pkg::CS_STOP, 1'b1, 1'b0);
        cpu_model_i.wr_byte(ctimer_pkg::ADDR_CMP_CTRL, 8'h00);
        cpu_model_i.wr_word(ctimer_pkg::ADDR_CAP_LO, c);
        cpu_model_i.rd_byte(ctimer_pkg::ADDR_CAP_LO, b);
        cpu_model_i.rd_byte(ctimer_pkg::ADDR_COUNT_HI, b);
        cmp_word({8'h00, b}, {8'h00, c[15:8]});
        {pin, cmp} = 2'b00;
        repeat (8) @(negedge sys_clk_i);
        pin = 1'b1;
        repeat (12) @(negedge sys_clk_i);
        flags(b);
        cmp_word({8'h00, b}, 16'h0000);
        set_mode(4'h0, ctimer_pkg::CS_STOP, 1'b1, 1'b0);
        cpu_model_i.wr_word(ctimer_pkg::ADDR_CAP_LO, ~c);
        cpu_model_i.rd_word(ctimer_pkg::ADDR_CAP_LO, got);
        cmp_word(got, c);
        $display("test capture top done");
        stop_test();
    end
endmodule : testbench
